// ==== slc_pkg.sv ====
// Functional notes
// [R1] phase adjust request bit always written zero
// [R2] lane zero id copies captured receiver id
// [R3] bit 7 enables descrambling, resets set
// [R4] lane count minus one, reset four lanes
// [R5] octets per frame: only 0, 1, 3
// [R6] frames per multiframe: only 0x0f, 0x1f
// [R7] one octet per frame forces 32 frames
// [R8] converter count minus one, reset two
// [R9] control bits per sample kept zero
// [R10] resolution field held at sixteen bits
// [R11] bits per sample field held at sixteen
// [R12] registers read back, reserved bits zero
// [R13] subclass field bits 7:5, resets one
package slc_pkg;

  // ----------------------------------------------------------------
  // device register map
  // ----------------------------------------------------------------
  localparam int SLC_NREG = 7;
  localparam int SLC_AW   = 12;
  localparam int SLC_DW   = 8;

  localparam int SLC_IDX_LANE_ZERO_IDENTIFIER = 0;
  localparam int SLC_IDX_SCRL = 1;
  localparam int SLC_IDX_OCT  = 2;
  localparam int SLC_IDX_MF   = 3;
  localparam int SLC_IDX_CONV = 4;
  localparam int SLC_IDX_CSN  = 5;
  localparam int SLC_IDX_NP   = 6;

  localparam logic [2:0] SLC_IDX_LAST = 3'h6;

  localparam logic [11:0] SLC_ADDR_RX_LANE_ZERO_IDENTIFIER = 12'h402;

  localparam logic [11:0] SLC_REG_ADDR [SLC_NREG] = '{
    12'h452, 12'h453, 12'h454, 12'h455, 12'h456, 12'h457, 12'h458};

  // writable bits; the rest are reserved and read zero
  localparam logic [7:0] SLC_REG_MASK [SLC_NREG] = '{
    8'h7f, 8'h9f, 8'hff, 8'h1f, 8'hff, 8'hdf, 8'hff};

  localparam logic [7:0] SLC_REG_RESET [SLC_NREG] = '{
    8'h00, 8'h83, 8'h00, 8'h1f, 8'h01, 8'h0f, 8'h2f};

  // ----------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------
  localparam int SLC_PHASE_ADJUST_REQUEST_BIT = 5;
  localparam int SLC_DESCR_BIT = 7;
  localparam int SLC_CS_LSB    = 6;
  localparam int SLC_SUBC_LSB  = 5;

  localparam logic [7:0] SLC_OCT_ONE  = 8'h00;
  localparam logic [7:0] SLC_OCT_TWO  = 8'h01;
  localparam logic [7:0] SLC_OCT_FOUR = 8'h03;
  localparam logic [4:0] SLC_MF_16    = 5'h0f;
  localparam logic [4:0] SLC_MF_32    = 5'h1f;
  localparam logic [4:0] SLC_RES_16   = 5'h0f;
  localparam logic [4:0] SLC_NP_16    = 5'h0f;
  localparam logic [1:0] SLC_CS_NONE  = 2'h0;
  localparam logic       SLC_PHASE_ADJUST_REQUEST_OFF = 1'b0;

  // ----------------------------------------------------------------
  // controller registers on avalon (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SLC_AVS_CONTROL = 8'h00;
  localparam logic [7:0] SLC_AVS_STATUS  = 8'h04;
  localparam logic [7:0] SLC_AVS_LINK    = 8'h08;
  localparam logic [7:0] SLC_AVS_CONV    = 8'h0c;
  localparam logic [7:0] SLC_AVS_RXID    = 8'h10;

  localparam int SLC_CTL_GO_BIT     = 0;
  localparam int SLC_STAT_BUSY_BIT  = 0;
  localparam int SLC_STAT_DONE_BIT  = 1;
  localparam int SLC_STAT_REJ_BIT   = 2;

  localparam int SLC_LK_LANE_LSB = 0;
  localparam int SLC_LK_DESCR    = 7;
  localparam int SLC_LK_OCT_LSB  = 8;
  localparam int SLC_LK_MF_LSB   = 16;
  localparam int SLC_LK_SUBC_LSB = 24;

  localparam logic [31:0] SLC_AVS_LINK_RST = 32'h011f_0083;
  localparam logic [31:0] SLC_AVS_CONV_RST = 32'h0000_0001;

endpackage

// ==== slc_link_if.sv ====
`timescale 1ns/10ps
interface slc_link_if
  import slc_pkg::*;
(
  input wire logic i_clock
);
  logic              req;
  logic              we;
  logic [SLC_AW-1:0] addr;
  logic [SLC_DW-1:0] wdata;
  logic              ack;
  logic [SLC_DW-1:0] rdata;

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport ctl (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface

// ==== slc_cfg_cell.sv ====
`timescale 1ns/10ps
module slc_cfg_cell
  import slc_pkg::*;
#(
  parameter logic [7:0] RESET_VAL  = 8'h00,
  parameter logic [7:0] WRITE_MASK = 8'hff
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_value
);
  logic [7:0] value_reg;
  logic [7:0] value_next;

  always_comb begin
    value_next = value_reg;
    if (i_we) begin
      value_next = i_wdata & WRITE_MASK; // R12
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      value_reg <= RESET_VAL & WRITE_MASK;
    end else begin
      value_reg <= value_next;
    end
  end

  assign o_value = value_reg;
endmodule

// ==== slc_cfg_dev.sv ====
`timescale 1ns/10ps
module slc_cfg_dev
  import slc_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  slc_link_if.dev         link,
  input  wire logic [4:0] i_rx_lane_zero_id,
  output logic            o_descramble_enable,
  output logic      [4:0] o_lane_count_m1,
  output logic      [7:0] o_octets_m1,
  output logic      [4:0] o_mf_len_m1,
  output logic      [7:0] o_converter_m1,
  output logic      [2:0] o_link_subclass_select,
  output logic      [4:0] o_lane_zero_identifier,
  output logic      [4:0] o_sample_bits_minus_one,
  output logic            o_frame_cfg_legal
);
  // ----------------------------------------------------------------
  // register cells
  // ----------------------------------------------------------------
  logic [7:0] value [SLC_NREG];

  genvar g;
  generate
    for (g = 0; g < SLC_NREG; g++) begin : g_cell
      slc_cfg_cell #(
        .RESET_VAL  (SLC_REG_RESET[g]),
        .WRITE_MASK (SLC_REG_MASK[g])
      ) u_cell (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_we    (link.req && link.we &&
                  (link.addr == SLC_REG_ADDR[g])), // R12
        .i_wdata (link.wdata),
        .o_value (value[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // read path and answer
  // ----------------------------------------------------------------
  logic       ack_reg;
  logic       ack_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       legal_reg;
  logic       legal_next;

  always_comb begin
    ack_next   = link.req;
    rdata_next = 8'h00;
    if (link.addr == SLC_ADDR_RX_LANE_ZERO_IDENTIFIER) begin
      rdata_next = {3'h0, i_rx_lane_zero_id};
    end
    for (int i = 0; i < SLC_NREG; i++) begin
      if (link.addr == SLC_REG_ADDR[i]) begin
        rdata_next = value[i]; // R12
      end
    end
    // high for a frame shape the receiver can lock to
    legal_next = ((value[SLC_IDX_OCT] == SLC_OCT_ONE) ||
                  (value[SLC_IDX_OCT] == SLC_OCT_TWO) ||
                  (value[SLC_IDX_OCT] == SLC_OCT_FOUR)) && // R5
                 ((value[SLC_IDX_MF][4:0] == SLC_MF_16) ||
                  (value[SLC_IDX_MF][4:0] == SLC_MF_32)); // R6
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
      legal_reg <= 1'b1;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      legal_reg <= legal_next;
    end
  end

  assign link.ack   = ack_reg;
  assign link.rdata = rdata_reg;

  // ----------------------------------------------------------------
  // settings to the receive datapath
  // ----------------------------------------------------------------
  assign o_descramble_enable     = value[SLC_IDX_SCRL][SLC_DESCR_BIT]; // R3
  assign o_lane_count_m1         = value[SLC_IDX_SCRL][4:0]; // R4
  assign o_octets_m1             = value[SLC_IDX_OCT]; // R5
  assign o_mf_len_m1             = value[SLC_IDX_MF][4:0]; // R6
  assign o_converter_m1          = value[SLC_IDX_CONV]; // R8
  assign o_link_subclass_select  = value[SLC_IDX_NP][7:SLC_SUBC_LSB]; // R13
  assign o_lane_zero_identifier  = value[SLC_IDX_LANE_ZERO_IDENTIFIER][4:0];
  assign o_sample_bits_minus_one = value[SLC_IDX_NP][4:0];
  assign o_frame_cfg_legal       = legal_reg;
endmodule

// ==== slc_cfg_ctl.sv ====
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module slc_cfg_ctl
  import slc_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_busy,
  slc_link_if.ctl          link
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_WR_WAIT
  } slc_state_t;

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle per access
  // ----------------------------------------------------------------
  logic        wait_reg;
  logic        wait_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic [31:0] link_cfg_reg;
  logic [31:0] link_cfg_next;
  logic [7:0]  conv_reg;
  logic [7:0]  conv_next;
  logic [4:0]  rx_id_reg;
  logic [4:0]  rx_id_next;
  logic        done_reg;
  logic        done_next;
  logic        rej_reg;
  logic        rej_next;
  logic        busy_reg;
  logic        busy_next;
  logic        wr_take;
  logic        go;

  slc_state_t  state_reg;
  slc_state_t  state_next;
  logic [2:0]  idx_reg;
  logic [2:0]  idx_next;
  logic        req_reg;
  logic        req_next;
  logic        we_reg;
  logic        we_next;
  logic [11:0] addr_reg;
  logic [11:0] addr_next;
  logic [7:0]  wdata_reg;
  logic [7:0]  wdata_next;

  // requested fields
  logic [4:0]  lanes;
  logic        descr;
  logic [7:0]  octets;
  logic [4:0]  mf_len;
  logic [2:0]  subclass;
  logic        legal;

  assign lanes    = link_cfg_reg[SLC_LK_LANE_LSB +: 5];
  assign descr    = link_cfg_reg[SLC_LK_DESCR];
  assign octets   = link_cfg_reg[SLC_LK_OCT_LSB +: 8];
  assign mf_len   = link_cfg_reg[SLC_LK_MF_LSB +: 5];
  assign subclass = link_cfg_reg[SLC_LK_SUBC_LSB +: 3];

  // refused before any write so the device never sees a bad frame
  assign legal = ((octets == SLC_OCT_ONE) || (octets == SLC_OCT_TWO) ||
                  (octets == SLC_OCT_FOUR)) && // R5
                 ((mf_len == SLC_MF_16) || (mf_len == SLC_MF_32)) && // R6
                 ((octets != SLC_OCT_ONE) || (mf_len == SLC_MF_32)); // R7

  assign wr_take = i_avs_write && !wait_reg;
  assign go      = wr_take && (i_avs_address == SLC_AVS_CONTROL) &&
                   i_avs_writedata[SLC_CTL_GO_BIT];

  always_comb begin
    wait_next     = !((i_avs_read || i_avs_write) && wait_reg);
    rd_next       = rd_reg;
    link_cfg_next = link_cfg_reg;
    conv_next     = conv_reg;
    if (i_avs_read && wait_reg) begin
      case (i_avs_address)
        SLC_AVS_STATUS: begin
          rd_next = 32'h0000_0000;
          rd_next[SLC_STAT_BUSY_BIT] = (state_reg != ST_IDLE);
          rd_next[SLC_STAT_DONE_BIT] = done_reg;
          rd_next[SLC_STAT_REJ_BIT]  = rej_reg;
        end
        SLC_AVS_LINK: rd_next = link_cfg_reg;
        SLC_AVS_CONV: rd_next = {24'h00_0000, conv_reg};
        SLC_AVS_RXID: rd_next = {27'h000_0000, rx_id_reg};
        default:      rd_next = 32'h0000_0000;
      endcase
    end
    // settings are frozen while a transfer runs
    if (wr_take && (state_reg == ST_IDLE)) begin
      case (i_avs_address)
        SLC_AVS_LINK: link_cfg_next = i_avs_writedata;
        SLC_AVS_CONV: conv_next     = i_avs_writedata[7:0];
        default:      ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // device register image
  // ----------------------------------------------------------------
  function automatic logic [7:0] image(input logic [2:0] k);
    logic [7:0] v;
    v = 8'h00;
    case (k)
      3'(SLC_IDX_LANE_ZERO_IDENTIFIER): begin
        // id lands in the same cycle as the first write, so not the reg
        v[4:0] = rx_id_next; // R2
        v[SLC_PHASE_ADJUST_REQUEST_BIT] = SLC_PHASE_ADJUST_REQUEST_OFF; // R1
      end
      3'(SLC_IDX_SCRL): begin
        v[4:0] = lanes;
        v[SLC_DESCR_BIT] = descr;
      end
      3'(SLC_IDX_OCT):  v = octets;
      3'(SLC_IDX_MF):   v[4:0] = mf_len;
      3'(SLC_IDX_CONV): v = conv_reg;
      3'(SLC_IDX_CSN): begin
        v[SLC_CS_LSB +: 2] = SLC_CS_NONE; // R9
        v[4:0] = SLC_RES_16; // R10
      end
      3'(SLC_IDX_NP): begin
        v[SLC_SUBC_LSB +: 3] = subclass;
        v[4:0] = SLC_NP_16; // R11
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // sequencer: read captured id, then write all seven registers
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    req_next   = 1'b0;
    we_next    = we_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    rx_id_next = rx_id_reg;
    done_next  = done_reg;
    rej_next   = rej_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go) begin
          done_next = 1'b0;
          rej_next  = !legal;
          if (legal) begin
            req_next   = 1'b1;
            we_next    = 1'b0;
            addr_next  = SLC_ADDR_RX_LANE_ZERO_IDENTIFIER; // R2
            state_next = ST_RD_WAIT;
          end
        end
      end
      ST_RD_WAIT: begin
        if (link.ack) begin
          rx_id_next = link.rdata[4:0]; // R2
          idx_next   = 3'h0;
          req_next   = 1'b1;
          we_next    = 1'b1;
          addr_next  = SLC_REG_ADDR[0];
          state_next = ST_WR_WAIT;
        end
      end
      ST_WR_WAIT: begin
        if (link.ack) begin
          if (idx_reg == SLC_IDX_LAST) begin
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end else begin
            idx_next   = idx_reg + 3'h1;
            req_next   = 1'b1;
            addr_next  = SLC_REG_ADDR[idx_reg + 3'h1];
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (req_next && we_next) begin
      wdata_next = (state_reg == ST_RD_WAIT) ? image(3'h0)
                                             : image(idx_next);
    end
    busy_next = (state_next != ST_IDLE);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wait_reg     <= 1'b1;
      rd_reg       <= 32'h0000_0000;
      link_cfg_reg <= SLC_AVS_LINK_RST;
      conv_reg     <= SLC_AVS_CONV_RST[7:0];
      rx_id_reg    <= 5'h00;
      done_reg     <= 1'b0;
      rej_reg      <= 1'b0;
      busy_reg     <= 1'b0;
      state_reg    <= ST_IDLE;
      idx_reg      <= 3'h0;
      req_reg      <= 1'b0;
      we_reg       <= 1'b0;
      addr_reg     <= 12'h000;
      wdata_reg    <= 8'h00;
    end else begin
      wait_reg     <= wait_next;
      rd_reg       <= rd_next;
      link_cfg_reg <= link_cfg_next;
      conv_reg     <= conv_next;
      rx_id_reg    <= rx_id_next;
      done_reg     <= done_next;
      rej_reg      <= rej_next;
      busy_reg     <= busy_next;
      state_reg    <= state_next;
      idx_reg      <= idx_next;
      req_reg      <= req_next;
      we_reg       <= we_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
    end
  end

  assign o_avs_readdata    = rd_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_busy            = busy_reg;
  assign link.req          = req_reg;
  assign link.we           = we_reg;
  assign link.addr         = addr_reg;
  assign link.wdata        = wdata_reg;
endmodule

// ==== slc_cfg_asserts.sv ====
`timescale 1ns/10ps
module slc_cfg_asserts
  import slc_pkg::*;
(
  input wire logic              i_clock,
  input wire logic              i_reset,
  input wire logic              req,
  input wire logic              we,
  input wire logic [SLC_AW-1:0] addr,
  input wire logic [SLC_DW-1:0] wdata,
  input wire logic              ack,
  input wire logic [SLC_DW-1:0] rdata
);
  // ----------------------------------------------------------------
  // helper state: last captured id and last octet count sent
  // ----------------------------------------------------------------
  logic       rd_id_reg;
  logic       rd_id_next;
  logic [4:0] id_reg;
  logic [4:0] id_next;
  logic [7:0] oct_reg;
  logic [7:0] oct_next;
  logic       wr_id;
  logic       wr_oct;
  logic       wr_mf;
  logic       wr_csn;
  logic       wr_np;

  assign wr_id  = req && we && (addr == 12'h452);
  assign wr_oct = req && we && (addr == 12'h454);
  assign wr_mf  = req && we && (addr == 12'h455);
  assign wr_csn = req && we && (addr == 12'h457);
  assign wr_np  = req && we && (addr == 12'h458);

  always_comb begin
    rd_id_next = rd_id_reg;
    if (req) begin
      rd_id_next = !we && (addr == SLC_ADDR_RX_LANE_ZERO_IDENTIFIER);
    end
    id_next  = (ack && rd_id_reg) ? rdata[4:0] : id_reg;
    oct_next = wr_oct ? wdata : oct_reg;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rd_id_reg <= 1'b0;
      id_reg    <= 5'h00;
      oct_reg   <= 8'h00;
    end else begin
      rd_id_reg <= rd_id_next;
      id_reg    <= id_next;
      oct_reg   <= oct_next;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_ack_follows_req: assert property (req |=> ack)
    else $error("device did not answer one cycle after request");
  a_ack_has_cause: assert property (ack |-> $past(req))
    else $error("answer without a request");
  a_req_spaced: assert property (req |=> !req ##1 1'b1)
    else $error("requests closer than two cycles");
  a_phase_adjust_request_clear: assert property (wr_id |-> !wdata[5])
    else $error("phase adjust request written set");
  a_lid_copied: assert property (wr_id |-> wdata[4:0] == id_reg)
    else $error("lane zero id differs from captured id");
  a_oct_valid: assert property (wr_oct |->
    (wdata inside {8'h00, 8'h01, 8'h03}))
    else $error("illegal octets per frame sent");
  a_mf_valid: assert property (wr_mf |->
    (wdata[4:0] inside {5'h0f, 5'h1f}))
    else $error("illegal frames per multiframe sent");
  a_one_oct_mf: assert property (wr_mf && oct_reg == 8'h00 |->
    wdata[4:0] == 5'h1f)
    else $error("one octet per frame without 32 frames");
  a_cs_zero: assert property (wr_csn |-> wdata[7:6] == 2'h0)
    else $error("control bits per sample not zero");
  a_res_sixteen: assert property (wr_csn |-> wdata[4:0] == 5'h0f)
    else $error("resolution not sixteen bits");
  a_np_sixteen: assert property (wr_np |-> wdata[4:0] == 5'h0f)
    else $error("bits per sample not sixteen");
endmodule

// ==== slc_cfg_regs_tb.sv ====
`timescale 1ns/10ps
module slc_cfg_regs_tb;
  import slc_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic [7:0]  av_addr = 8'h00;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic [4:0]  rx_id = 5'h00;
  wire  [40:0] outs;
  logic        busy;
  logic        legal_b;
  int          err_total = 0;
  int          n_compared = 0;
  int          seed = 32'h46d9;

  always #4 i_clock = ~i_clock;

  // ----------------------------------------------------------------
  // two links: controller to device, and bench to a second device
  // ----------------------------------------------------------------
  slc_link_if link_a (.i_clock(i_clock));
  slc_link_if link_b (.i_clock(i_clock));

  slc_cfg_ctl slc_cfg_ctl_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
    .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .o_busy(busy),
    .link(link_a.ctl));
  slc_cfg_dev slc_cfg_dev_i (
    .i_clock(i_clock), .i_reset(i_reset), .link(link_a.dev),
    .i_rx_lane_zero_id(rx_id), .o_descramble_enable(outs[40]),
    .o_lane_count_m1(outs[39:35]), .o_octets_m1(outs[34:27]),
    .o_mf_len_m1(outs[26:22]), .o_converter_m1(outs[21:14]),
    .o_link_subclass_select(outs[13:11]),
    .o_lane_zero_identifier(outs[10:6]),
    .o_sample_bits_minus_one(outs[5:1]), .o_frame_cfg_legal(outs[0]));
  slc_cfg_dev slc_cfg_dev_b_i (
    .i_clock(i_clock), .i_reset(i_reset), .link(link_b.dev),
    .i_rx_lane_zero_id(rx_id), .o_descramble_enable(),
    .o_lane_count_m1(), .o_octets_m1(), .o_mf_len_m1(),
    .o_converter_m1(), .o_link_subclass_select(),
    .o_lane_zero_identifier(), .o_sample_bits_minus_one(),
    .o_frame_cfg_legal(legal_b));
  slc_cfg_asserts slc_cfg_asserts_i (
    .i_clock(i_clock), .i_reset(i_reset), .req(link_a.req),
    .we(link_a.we), .addr(link_a.addr), .wdata(link_a.wdata),
    .ack(link_a.ack), .rdata(link_a.rdata));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    err_total++;
    $display("MISMATCH t=%0t wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic avs(input logic w, input logic [7:0] a,
                     input logic [31:0] dv, output logic [31:0] q);
    int k;
    @(posedge i_clock);
    av_addr  <= a;
    av_wdata <= dv;
    av_rd    <= !w;
    av_wr    <= w;
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (av_wait !== 1'b0 && k < 50);
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    if (k >= 50) timed_out();
  endtask

  task automatic lb(input logic w, input logic [11:0] a,
                    input logic [7:0] dv, output logic [7:0] q);
    int k;
    @(posedge i_clock);
    link_b.req   <= 1'b1;
    link_b.we    <= w;
    link_b.addr  <= a;
    link_b.wdata <= dv;
    @(posedge i_clock);
    // released lines show junk, not the last value
    link_b.req   <= 1'b0;
    link_b.addr  <= ~a;
    link_b.wdata <= ~dv;
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (link_b.ack !== 1'b1 && k < 8);
    q = link_b.rdata;
    if (k >= 8) timed_out();
  endtask

  // busy write must be ignored; link word then reads back unchanged
  task automatic program_link(input logic [31:0] lk, input logic [31:0] cv,
                              input logic [31:0] st);
    logic [31:0] q;
    int k;
    avs(1'b1, SLC_AVS_LINK, lk, q);
    avs(1'b1, SLC_AVS_CONV, cv, q);
    avs(1'b1, SLC_AVS_CONTROL, 32'h1, q);
    if (st == 32'h2) avs(1'b1, SLC_AVS_LINK, ~lk, q);
    chk(64'(busy), 64'(st == 32'h2));
    k = 0;
    do begin
      avs(1'b0, SLC_AVS_STATUS, 32'h0, q);
      k++;
    end while (q !== st && k < 100);
    if (q !== st) timed_out();
    chk(64'(q), 64'(st));
    avs(1'b0, SLC_AVS_LINK, 32'h0, q);
    chk(64'(q), 64'(lk));
  endtask

  function automatic logic [63:0] expect_outs(input logic [31:0] lk,
      input logic [7:0] cv, input logic [4:0] id);
    return {23'h0, lk[7], lk[4:0], lk[15:8], lk[20:16], cv, lk[26:24],
            id, 5'h0f, 1'b1};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  logic [28:0] ops [9] = '{
    {1'b1, 12'h454, 8'h02, 8'h00}, {1'b1, 12'h454, 8'h03, 8'h01},
    {1'b1, 12'h455, 8'hee, 8'h00}, {1'b0, 12'h455, 8'h00, 8'h0e},
    {1'b1, 12'h455, 8'hef, 8'h01}, {1'b0, 12'h455, 8'h00, 8'h0f},
    {1'b1, 12'h453, 8'hff, 8'h01}, {1'b0, 12'h453, 8'h00, 8'h9f},
    {1'b0, 12'h459, 8'h00, 8'h00}};

  initial begin
    logic [31:0] q;
    logic [31:0] lk;
    logic [31:0] cv;
    logic [31:0] r;
    logic [7:0]  oct;
    logic [7:0]  d;
    link_b.req = 1'b0;
    link_b.we = 1'b0;
    link_b.addr = 12'h000;
    link_b.wdata = 8'h00;
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    chk(64'(outs), expect_outs(SLC_AVS_LINK_RST, 8'h01, 5'h00));
    avs(1'b0, SLC_AVS_LINK, 32'h0, q);
    chk(64'(q), 64'(SLC_AVS_LINK_RST));
    avs(1'b0, SLC_AVS_CONV, 32'h0, q);
    chk(64'(q), 64'(SLC_AVS_CONV_RST));
    avs(1'b1, 8'h20, 32'hffff_ffff, q);
    avs(1'b0, 8'h20, 32'h0, q);
    chk(64'(q), 64'h0);
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      case (r[1:0])
        2'h0: oct = 8'h00;
        2'h1: oct = 8'h01;
        default: oct = 8'h03;
      endcase
      lk = {7'h0, r[3], 3'h0, ((oct == 8'h00 || r[2]) ? 5'h1f : 5'h0f),
            oct, r[4], 2'h0, r[9:5]};
      cv = {31'h0, r[10]};
      if (i == 0) lk = 32'h000f_0300;
      if (i == 0) cv = 32'h0;
      rx_id <= r[15:11];
      program_link(lk, cv, 32'h2);
      chk(64'(outs), expect_outs(lk, cv[7:0], rx_id));
      avs(1'b0, SLC_AVS_RXID, 32'h0, q);
      chk(64'(q), 64'(rx_id));
    end
    program_link(32'h011f_0200, 32'h0, 32'h4);
    program_link(32'h010f_0000, 32'h0, 32'h4);
    chk(64'(outs), expect_outs(lk, cv[7:0], rx_id));
    for (int j = 0; j < 9; j++) begin
      lb(ops[j][28], ops[j][27:16], ops[j][15:8], d);
      repeat (2) @(posedge i_clock);
      chk(64'(ops[j][28] ? {7'h0, legal_b} : d), 64'(ops[j][7:0]));
    end
    lb(1'b0, SLC_ADDR_RX_LANE_ZERO_IDENTIFIER, 8'h00, d);
    chk(64'(d), 64'(rx_id));
    tally_and_finish();
  end
endmodule
